// [rtl/smws_defs.svh]
// constants for the static memory wait sequencer
// assumes inclusion by the package, the wait counter and the sequencer files
`ifndef SMWS_DEFS_SVH
`define SMWS_DEFS_SVH
`define SMWS_AW            32
`define SMWS_DW            32
`define SMWS_CFG_W         12
`define SMWS_CFG_SEQ       12'h068
`define SMWS_CFG_BURST     12'hE60
`define SMWS_CFG_NSEQ      12'h058
`define SMWS_WAIT_SEQ      4'h3
`define SMWS_WAIT_BURST    4'h3
`define SMWS_WAIT_NSEQ     4'h5
`define SMWS_WAIT_FIRST    4'h4
`define SMWS_WAIT_DFLT     4'h1
`define SMWS_ADDR_RST      32'h0000_0000
`endif

// [rtl/smws_pkg.sv]
// types for the static memory wait sequencer
// assumes smws_defs.svh is on the include path
`include "smws_defs.svh"
package smws_pkg;
  typedef logic [`SMWS_AW-1:0] smws_addr_t;
  typedef logic [3:0]          smws_wait_t;
  typedef enum logic [3:0] {
    SMWS_IDLE = 4'b0001,
    SMWS_WAIT = 4'b0010,
    SMWS_DONE = 4'b0100,
    SMWS_HOLD = 4'b1000
  } smws_state_e;
endpackage : smws_pkg

// [rtl/smws_wait_if.sv]
// wait counter handshake between sequencer and counter
// assumes one clock domain
`timescale 1ns/10ps
interface smws_wait_if;
  logic                start;
  smws_pkg::smws_wait_t count;
  logic                last;
  modport seq (output start, output count, input last);
  modport cnt (input start, input count, output last);
endinterface : smws_wait_if

// [rtl/smws_wait_counter.sv]
// wait cycle counter, one BCLK per wait cycle
// assumes start pulses once per access
`timescale 1ns/10ps
`include "smws_defs.svh"
module smws_wait_counter (
  input  wire logic clock,
  input  wire logic rst,
  smws_wait_if.cnt  wif
);
  smws_pkg::smws_wait_t remain;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      remain <= 4'h0;
    end else if (wif.start) begin
      remain <= wif.count; // R2
    end else if (remain != 4'h0) begin
      remain <= remain - 4'h1;
    end
  end

  assign wif.last = (remain == 4'h1) && !wif.start;
endmodule : smws_wait_counter

// [rtl/smws_sequencer.sv]
// static memory wait sequencer: bus transfer to external strobes
// assumes bus inputs synchronous to clock; write enable re-strobed on the falling edge
//
// What this block does
// (R1) config 068 gives sequential reads with three wait cycles each
// (R2) each wait cycle lasts one clock; count follows timing config
// (R3) latch bus address only when address valid and selected
// (R4) first access drives address, chip select and output enable for data
// (R5) sequential reads do not reassert chip select or output enable
// (R6) config E60 gives burst reads, three waits on later beats
// (R7) first beat of a burst uses the normal wait time
// (R8) in burst mode latch address only when burst flag also valid
// (R9) other party drops burst flag when bus address changes
// (R10) config 068 gives sequential writes with three wait cycles each
// (R11) write data valid with address, chip select and write enable
// (R12) sequential writes keep chip select off, write enable on falling edge
// (R13) config 058 gives non-sequential reads with five wait cycles
// (R14) address, chip select and output enable stay stable in wait; release after last wait
`timescale 1ns/10ps
`include "smws_defs.svh"
module smws_sequencer (
  input  wire logic                   clock,
  input  wire logic                   rst,
  input  wire logic [`SMWS_CFG_W-1:0] memory_timing_config,
  input  wire logic [`SMWS_AW-1:0]    bus_addr,
  input  wire logic                   bus_addr_valid,
  input  wire logic                   bus_dsel,
  input  wire logic                   bus_seq,
  input  wire logic                   bus_write,
  input  wire logic [`SMWS_DW-1:0]    bus_wdata,
  input  wire logic                   burst_mode_flag,
  input  wire logic [`SMWS_DW-1:0]    ext_rdata,
  output logic [`SMWS_AW-1:0]         ext_memory_address,
  output logic                        ext_chip_select_n,
  output logic                        ext_output_enable_n,
  output logic                        ext_write_enable_n,
  output logic [`SMWS_DW-1:0]         ext_wdata,
  output logic                        ext_wdata_oe,
  output logic [`SMWS_DW-1:0]         bus_rdata,
  output logic                        bus_done,
  output logic                        wait_period
);
  smws_wait_if wif ();
  smws_wait_counter u_cnt (.clock(clock), .rst(rst), .wif(wif));

  smws_pkg::smws_state_e state;
  logic       in_seq;
  logic       in_write;
  logic       burst_active;
  logic       take;
  smws_pkg::smws_wait_t next_count;

  // decode the wait count from config, mode and beat
  function automatic smws_pkg::smws_wait_t wait_of(input logic [`SMWS_CFG_W-1:0] cfg,
                                                  input logic seq,
                                                  input logic burst_beat);
    begin
      if (cfg == `SMWS_CFG_BURST) begin
        wait_of = burst_beat ? `SMWS_WAIT_BURST : `SMWS_WAIT_FIRST; // R6 R7
      end else if (cfg == `SMWS_CFG_SEQ) begin
        wait_of = `SMWS_WAIT_SEQ; // R1 R10
      end else if (cfg == `SMWS_CFG_NSEQ) begin
        wait_of = `SMWS_WAIT_NSEQ; // R13
      end else begin
        wait_of = seq ? `SMWS_WAIT_DFLT : `SMWS_WAIT_DFLT;
      end
    end
  endfunction : wait_of

  // burst mode needs the flag as well; a dropped flag ends the burst
  assign take = (state == smws_pkg::SMWS_IDLE) && bus_addr_valid && bus_dsel
              && ((memory_timing_config != `SMWS_CFG_BURST) || burst_mode_flag); // R3 R8
  assign next_count = wait_of(memory_timing_config, bus_seq, burst_active && bus_seq);
  assign wif.start = take;
  assign wif.count = next_count;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= smws_pkg::SMWS_IDLE;
    end else begin
      case (state)
        smws_pkg::SMWS_IDLE: begin
          if (take) begin
            state <= smws_pkg::SMWS_WAIT;
          end
        end
        smws_pkg::SMWS_WAIT: begin
          if (wif.last) begin
            state <= smws_pkg::SMWS_DONE; // R14
          end
        end
        smws_pkg::SMWS_DONE: begin
          state <= smws_pkg::SMWS_IDLE;
        end
        default: begin
          state <= smws_pkg::SMWS_IDLE;
        end
      endcase
    end
  end

  // access attributes held for the whole wait
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ext_memory_address <= `SMWS_ADDR_RST;
      in_seq             <= 1'b0;
      in_write           <= 1'b0;
      ext_wdata          <= '0;
    end else if (take) begin
      ext_memory_address <= bus_addr; // R3 R8
      in_seq             <= bus_seq;
      in_write           <= bus_write;
      ext_wdata          <= bus_wdata; // R11
    end
  end

  // burst stays open while flag held; the other party drops it on address change
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      burst_active <= 1'b0;
    end else if (!burst_mode_flag || memory_timing_config != `SMWS_CFG_BURST) begin
      burst_active <= 1'b0; // R9
    end else if (state == smws_pkg::SMWS_DONE) begin
      burst_active <= 1'b1;
    end
  end

  // chip select and output enable only on first access, held through wait
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ext_chip_select_n   <= 1'b1;
      ext_output_enable_n <= 1'b1;
      ext_wdata_oe        <= 1'b0;
      wait_period         <= 1'b0;
    end else if (take) begin
      ext_chip_select_n   <= bus_seq; // R4 R5 R12
      ext_output_enable_n <= bus_seq || bus_write; // R4 R5
      ext_wdata_oe        <= bus_write; // R11
      wait_period         <= 1'b1; // R2
    end else if (state == smws_pkg::SMWS_WAIT && wif.last) begin
      ext_chip_select_n   <= 1'b1; // R14
      ext_output_enable_n <= 1'b1;
      wait_period         <= 1'b0;
    end else if (state == smws_pkg::SMWS_DONE) begin
      ext_wdata_oe        <= 1'b0; // data drive outlasts the write enable by half a cycle
    end
  end

  // data sampled at the end of the last wait cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bus_rdata <= '0;
      bus_done  <= 1'b0;
    end else begin
      bus_done <= (state == smws_pkg::SMWS_WAIT) && wif.last; // R14
      if ((state == smws_pkg::SMWS_WAIT) && wif.last && !in_write) begin
        bus_rdata <= ext_rdata; // R4 R5
      end
    end
  end

  // write enable from a falling-edge flop: opens half a cycle into the wait,
  // closes half a cycle after it, while write data is still driven
  always_ff @(negedge clock or posedge rst) begin
    if (rst) begin
      ext_write_enable_n <= 1'b1;
    end else begin
      ext_write_enable_n <= !((state == smws_pkg::SMWS_WAIT) && in_write); // R11 R12
    end
  end

  // assertions
  sequence s_take;
    take;
  endsequence

  sequence s_wait3;
    wait_period [*3];
  endsequence

  sequence s_wait4;
    wait_period [*4];
  endsequence

  sequence s_wait5;
    wait_period [*5];
  endsequence

  // the access closes: wait period ended and done pulsed on the same edge
  sequence s_release;
    !wait_period && bus_done;
  endsequence

  AST_SEQ_THREE_WAITS: assert property (@(posedge clock) disable iff (rst) // R1
    (s_take and (memory_timing_config == `SMWS_CFG_SEQ)) |=> s_wait3 ##1 !wait_period)
    else $error("sequential config did not give three waits");

  AST_NSEQ_FIVE_WAITS: assert property (@(posedge clock) disable iff (rst) // R13
    (take && memory_timing_config == `SMWS_CFG_NSEQ) |=> wait_period [*5] ##1 !wait_period)
    else $error("non-sequential config did not give five waits");

  AST_BURST_FIRST: assert property (@(posedge clock) disable iff (rst) // R7
    (take && memory_timing_config == `SMWS_CFG_BURST && !bus_seq)
      |=> wait_period [*4] ##1 !wait_period)
    else $error("first burst beat not at normal wait");

  AST_ADDR_GATE: assert property (@(posedge clock) disable iff (rst) // R3
    !(bus_addr_valid && bus_dsel) |=> $stable(ext_memory_address))
    else $error("address captured without valid select");

  AST_BURST_GATE: assert property (@(posedge clock) disable iff (rst) // R8
    (state == smws_pkg::SMWS_IDLE && memory_timing_config == `SMWS_CFG_BURST
      && !burst_mode_flag) |=> $stable(ext_memory_address))
    else $error("burst address captured without flag");

  AST_SEQ_NO_STROBE: assert property (@(posedge clock) disable iff (rst) // R5
    (take && bus_seq) |=> ext_chip_select_n && ext_output_enable_n)
    else $error("strobe reasserted on sequential beat");

  AST_FIRST_STROBE: assert property (@(posedge clock) disable iff (rst) // R4
    (take && !bus_seq && !bus_write) |=> !ext_chip_select_n && !ext_output_enable_n)
    else $error("first read lacks strobes");

  AST_STABLE_WAIT: assert property (@(posedge clock) disable iff (rst) // R14
    (wait_period && $past(wait_period)) |-> $stable(ext_memory_address)
      && $stable(ext_chip_select_n))
    else $error("address or strobe moved during wait");

  AST_DONE_AFTER: assert property (@(posedge clock) disable iff (rst) // R2
    $fell(wait_period) |-> bus_done)
    else $error("release not aligned to end of wait");

  AST_WRITE_OE: assert property (@(posedge clock) disable iff (rst) // R11
    (take && bus_write) |=> ext_wdata_oe && ext_output_enable_n)
    else $error("write data not driven with write");

  AST_SEQ_WRITE_WAITS: assert property (@(posedge clock) disable iff (rst) // R10
    (take && bus_write && memory_timing_config == `SMWS_CFG_SEQ) |=> s_wait3 ##1 s_release)
    else $error("sequential write did not give three waits");

  AST_BURST_LATER: assert property (@(posedge clock) disable iff (rst) // R6
    (take && memory_timing_config == `SMWS_CFG_BURST && bus_seq && burst_active)
      |=> s_wait3 ##1 s_release)
    else $error("later burst beat not at burst wait");

  AST_NSEQ_RELEASE: assert property (@(posedge clock) disable iff (rst) // R13
    (take && memory_timing_config == `SMWS_CFG_NSEQ) |=> s_wait5 ##1 s_release)
    else $error("non-sequential access not released after five waits");

  AST_BURST_FIRST_RELEASE: assert property (@(posedge clock) disable iff (rst) // R7
    (take && memory_timing_config == `SMWS_CFG_BURST && !bus_seq)
      |=> s_wait4 ##1 s_release)
    else $error("first burst beat not released after normal wait");

  AST_WAIT_HOLDS: assert property (@(posedge clock) disable iff (rst) // R2
    (wait_period && !wif.last) |=> wait_period)
    else $error("wait period cut short");

  AST_WAIT_ENDS: assert property (@(posedge clock) disable iff (rst) // R14
    (wait_period && wif.last) |=> s_release)
    else $error("access not released after last wait");

  AST_DONE_PULSE: assert property (@(posedge clock) disable iff (rst) // R14
    bus_done |=> !bus_done)
    else $error("done longer than one cycle");

  AST_OE_STABLE: assert property (@(posedge clock) disable iff (rst) // R14
    (wait_period && $past(wait_period)) |-> $stable(ext_output_enable_n)
      && $stable(ext_wdata_oe))
    else $error("output enable or data drive moved during wait");

  AST_SEQ_WRITE_CS: assert property (@(posedge clock) disable iff (rst) // R12
    (take && bus_seq && bus_write) |=> ext_chip_select_n && ext_wdata_oe)
    else $error("chip select asserted on sequential write");

  AST_WRITE_CS_FIRST: assert property (@(posedge clock) disable iff (rst) // R11
    (take && !bus_seq && bus_write) |=> !ext_chip_select_n && ext_wdata_oe)
    else $error("first write lacks chip select or data");

  // checked on the falling edge, where the write enable is launched
  AST_WE_FALLING: assert property (@(negedge clock) disable iff (rst) // R12
    ($rose(wait_period) && in_write) |-> ext_write_enable_n ##1 !ext_write_enable_n)
    else $error("write enable not opened on the falling edge");

  AST_WE_OFF_READ: assert property (@(posedge clock) disable iff (rst) // R11
    (wait_period && !in_write) |-> ext_write_enable_n)
    else $error("write enable during a read");

  AST_WE_WITH_DATA: assert property (@(posedge clock) disable iff (rst) // R11
    !ext_write_enable_n |-> ext_wdata_oe && wait_period)
    else $error("write enable without driven data");

  AST_RDATA_LOAD: assert property (@(posedge clock) disable iff (rst) // R4 R5
    (wait_period && wif.last && !in_write) |=> bus_rdata == $past(ext_rdata))
    else $error("read data not taken at end of wait");

  AST_ADDR_TAKEN: assert property (@(posedge clock) disable iff (rst) // R3 R8
    take |=> ext_memory_address == $past(bus_addr))
    else $error("address not latched on take");

  AST_STROBES_IDLE: assert property (@(posedge clock) disable iff (rst) // R14
    !wait_period |-> ext_chip_select_n && ext_output_enable_n)
    else $error("strobe active outside the wait");
endmodule : smws_sequencer

// [verif/smws_mem_model.sv]
// external static memory model: read data from address, captures writes
// assumes active low strobes from the sequencer
`timescale 1ns/10ps
module smws_mem_model (
  input  wire logic        clock,
  input  wire logic [31:0] ext_memory_address,
  input  wire logic        ext_write_enable_n,
  input  wire logic [31:0] ext_wdata,
  input  wire logic        ext_wdata_oe,
  output logic      [31:0] ext_rdata,
  output logic      [31:0] last_wdata
);
  // content follows address alone, so sequential beats need no strobe
  assign ext_rdata = ext_memory_address ^ 32'h5A5A_C3C3;
  // sampled on the rising edge, clear of the falling edge that strobes
  always @(posedge clock) begin
    if (!ext_write_enable_n && ext_wdata_oe) begin
      last_wdata <= ext_wdata;
    end
  end
endmodule : smws_mem_model

// [verif/static_memory_wait_sequencer_tb_top.sv]
// bench for the static memory wait sequencer
// assumes design files and the memory model are compiled first
`timescale 1ns/10ps
module static_memory_wait_sequencer_tb_top;
  typedef struct {
    logic rd; logic [3:0] w; logic cs; logic [31:0] a; logic [31:0] d;
  } smws_note_s;
  logic        clock = 0;
  logic        rst = 1;
  logic [11:0] memory_timing_config = 12'h068;
  logic [31:0] bus_addr = 0, bus_wdata = 0, ext_rdata, ext_memory_address;
  logic [31:0] ext_wdata, bus_rdata, last_wdata, wc = 0;
  logic        bus_addr_valid = 0, bus_dsel = 0, bus_seq = 0, bus_write = 0;
  logic        burst_mode_flag = 0, ext_chip_select_n, ext_output_enable_n;
  logic        ext_write_enable_n, ext_wdata_oe, bus_done, wait_period;
  logic        scs = 0, soe = 0, swe = 0, bad = 0;
  smws_note_s  q[$];
  smws_note_s  n;
  int          mismatches = 0, num_checks = 0, i;
  logic [31:0] seed = 32'h122f1674;
  smws_sequencer uut (.clock, .rst, .memory_timing_config, .bus_addr, .bus_addr_valid,
    .bus_dsel, .bus_seq, .bus_write, .bus_wdata, .burst_mode_flag, .ext_rdata,
    .ext_memory_address, .ext_chip_select_n, .ext_output_enable_n, .ext_write_enable_n,
    .ext_wdata, .ext_wdata_oe, .bus_rdata, .bus_done, .wait_period);
  smws_mem_model mem (.clock, .ext_memory_address, .ext_write_enable_n, .ext_wdata,
    .ext_wdata_oe, .ext_rdata, .last_wdata);
  initial begin
    forever #12.5 clock = ~clock;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  // request held until done, then one idle edge before the next
  task automatic xfer(input logic [11:0] c, input logic w, input logic s,
                      input logic [3:0] nw);
    smws_note_s e;
    int k;
    e.a = $random(seed);
    e.d = w ? $random(seed) : e.a ^ 32'h5A5A_C3C3;
    e.rd = !w;
    e.w = nw;
    e.cs = !s;
    q.push_back(e);
    memory_timing_config <= c;
    bus_addr <= e.a;
    bus_wdata <= e.d;
    bus_write <= w;
    bus_seq <= s;
    bus_addr_valid <= 1;
    bus_dsel <= 1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (bus_done !== 1'b1 && k < 40);
    if (k >= 40) check(0, 1);
    bus_addr_valid <= 0;
    @(posedge clock);
  endtask : xfer
  // a request that must not be taken
  task automatic ignore(input logic [11:0] c, input logic d, input logic f);
    memory_timing_config <= c;
    bus_addr <= $random(seed);
    bus_addr_valid <= 1;
    bus_dsel <= d;
    burst_mode_flag <= f;
    repeat (12) @(posedge clock);
    bus_addr_valid <= 0;
    @(posedge clock);
  endtask : ignore
  always @(posedge clock) begin
    if (wait_period === 1'b1) begin
      wc++;
      scs |= !ext_chip_select_n;
      soe |= !ext_output_enable_n;
      swe |= !ext_write_enable_n;
      if (q.size() > 0 && ext_memory_address !== q[0].a) bad = 1;
    end
    if (bus_done === 1'b1) begin
      if (q.size() == 0) check(1, 0);
      else begin
        n = q.pop_front();
        check(wc, n.w);
        check(scs, n.cs);
        check(soe, n.cs & n.rd);
        check(swe, !n.rd);
        check(bad, 0);
        check(n.rd ? bus_rdata : last_wdata, n.d);
      end
      {wc, scs, soe, swe, bad} = 0;
    end
  end
  initial begin
    repeat (3000) @(posedge clock);
    mismatches++;
    stop_test();
  end
  initial begin
    repeat (16) @(posedge clock);
    rst <= 0;
    @(posedge clock);
    for (i = 0; i < 4; i++) xfer(12'h068, 0, i > 0, 4'h3);
    $display("sequential read test ended");
    burst_mode_flag <= 1;
    xfer(12'hE60, 0, 0, 4'h4);
    for (i = 0; i < 3; i++) xfer(12'hE60, 0, 1, 4'h3);
    ignore(12'hE60, 1, 0);
    $display("burst read test ended");
    for (i = 0; i < 4; i++) xfer(12'h068, 1, i > 0, 4'h3);
    $display("sequential write test ended");
    xfer(12'h058, 0, 0, 4'h5);
    xfer(12'h000, 0, 0, 4'h1);
    ignore(12'h068, 0, 0);
    $display("wait and select test ended");
    stop_test();
  end
endmodule : static_memory_wait_sequencer_tb_top
